/* File: rtl/config_fuse_decoder.v */
`timescale 1ns/10ps
`include "config_fuse_decoder_map.vh"

// Summary of operation
// - boot protect bit 1 allows, 0 blocks writes
// - size codes x11, x00 mean no boot segment
// - codes 110/010 give small segment to 0003ff
// - codes 101/001 give medium segment to 000fff
// - general protect bit 1 allows, 0 blocks writes
// - general code 11 none, 10 standard, 0x reserved
// - fuse enable 1: watchdog always on, oscillator on
// - fuse enable 0: software bit controls watchdog
// - window select 1 non-window, 0 window mode
// - prescale bit set 128, clear 32
// - postscale 1111 is 32768, 1110 is 16384
// - power-up timer 000 off, else 2 to 128 ms
// - debug reserves first 80 RAM bytes, two pins
// - one configured pin pair carries debug data, clock
// - primary pair shares programming pins, alternates separate
// - 24-bit words, low 16 bits, table readable
module config_fuse_decoder #(
  parameter VECTOR_END = 24'h0000ff,
  parameter FLASH_END = 24'h001fff,
  parameter HOLD_BASE_CYCLES = `HOLD_BASE_MS * `CLK_KHZ
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  output reg nvm_rd_o,
  output reg [23:0] nvm_addr_o,
  input wire [23:0] nvm_data_i,
  input wire tbl_rd_i,
  input wire [23:0] tbl_addr_i,
  output reg [23:0] tbl_data_o,
  output reg tbl_valid_o,
  input wire flash_wr_req_i,
  input wire [23:0] flash_wr_addr_i,
  output wire flash_wr_allow_o,
  output reg config_valid_o,
  output reg boot_segment_present_o,
  output reg boot_high_security_o,
  output reg [23:0] boot_segment_end_o,
  output reg general_code_protect_o,
  output reg general_security_reserved_o,
  input wire software_watchdog_enable_i,
  output wire watchdog_enable_o,
  output wire low_power_rc_oscillator_en_o,
  output reg watchdog_window_mode_o,
  output reg [7:0] watchdog_prescale_o,
  output reg [15:0] watchdog_postscale_o,
  output reg powerup_timer_done_o,
  output reg [24:0] powerup_delay_cycles_o,
  input wire debug_enable_i,
  input wire [1:0] debug_pair_i,
  input wire [15:0] ram_addr_i,
  output wire ram_user_blocked_o,
  output reg [2:0] pair_reserved_o,
  input wire dbg_data_out_i,
  input wire dbg_data_oe_i,
  output reg dbg_data_in_o,
  output reg dbg_clock_o,
  input wire [2:0] debug_data_pin_i,
  output wire [2:0] debug_data_pin_o,
  output wire [2:0] debug_data_pin_oe_o,
  input wire [2:0] debug_clock_pin_i,
  output wire program_pins_shared_o
);

  localparam ST_LOAD = 2'b00;
  localparam ST_TIMER = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state;
  reg [1:0] word_idx;
  reg issued;
  reg [15:0] cfg_word [0:3];
  reg [24:0] hold_count;
  reg debug_on;
  reg [1:0] pair_sel;
  reg [2:0] data_meta;
  reg [2:0] data_sync;
  reg [2:0] clock_meta;
  reg [2:0] clock_sync;
  reg [1:0] strap_meta;
  reg [1:0] strap_sync;
  reg dbg_en_meta;
  reg dbg_en_sync;
  reg [24:0] next_delay;
  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // map a table-read address to a word slot, 3'b100 when unmapped
  function [2:0] word_slot;
    input [23:0] addr;
    begin
      case (addr)
        `CFG_ADDR_BOOT: word_slot = 3'h0;
        `CFG_ADDR_GENERAL: word_slot = 3'h1;
        `CFG_ADDR_WATCHDOG: word_slot = 3'h2;
        `CFG_ADDR_POWER_ON: word_slot = 3'h3;
        default: word_slot = 3'h4;
      endcase
    end
  endfunction

  // slot number back to its address, used by the loader
  function [23:0] slot_addr;
    input [1:0] slot;
    begin
      case (slot)
        2'h0: slot_addr = `CFG_ADDR_BOOT;
        2'h1: slot_addr = `CFG_ADDR_GENERAL;
        2'h2: slot_addr = `CFG_ADDR_WATCHDOG;
        default: slot_addr = `CFG_ADDR_POWER_ON;
      endcase
    end
  endfunction

  // boot size code to segment end; zero means no boot segment
  function [23:0] boot_end;
    input [2:0] size;
    begin
      case (size)
        `BOOT_SMALL_STD, `BOOT_SMALL_HIGH: begin
          boot_end = `BOOT_SMALL_END;
        end
        `BOOT_MEDIUM_STD, `BOOT_MEDIUM_HIGH: begin
          boot_end = `BOOT_MEDIUM_END;
        end
        default: begin
          boot_end = 24'h000000;
        end
      endcase
    end
  endfunction

  wire [15:0] boot_word = cfg_word[0];
  wire [15:0] gen_word = cfg_word[1];
  wire [15:0] wdt_word = cfg_word[2];
  wire [15:0] por_word = cfg_word[3];
  wire [2:0] boot_size = boot_word[`BOOT_SIZE_MSB:`BOOT_SIZE_LSB];
  wire [1:0] gen_sec = gen_word[`GEN_SEC_MSB:`GEN_SEC_LSB];
  wire [3:0] post_code = wdt_word[`WDT_POST_MSB:`WDT_POST_LSB];
  wire [2:0] hold_code = por_word[`HOLD_MSB:`HOLD_LSB];
  wire [2:0] tbl_slot = word_slot(tbl_addr_i);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before any logic looks at a pin

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_meta <= 3'h0;
      data_sync <= 3'h0;
      clock_meta <= 3'h0;
      clock_sync <= 3'h0;
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
      dbg_en_meta <= 1'b0;
      dbg_en_sync <= 1'b0;
    end else if (ce_i) begin
      data_meta <= debug_data_pin_i;
      data_sync <= data_meta;
      clock_meta <= debug_clock_pin_i;
      clock_sync <= clock_meta;
      strap_meta <= debug_pair_i;
      strap_sync <= strap_meta;
      dbg_en_meta <= debug_enable_i;
      dbg_en_sync <= dbg_en_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loader: fetch the four words once after reset, then hold them

  // one read per word, data taken at the edge that ends the strobe
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_LOAD;
      word_idx <= 2'h0;
      issued <= 1'b0;
      nvm_rd_o <= 1'b0;
      nvm_addr_o <= `CFG_ADDR_BOOT;
      config_valid_o <= 1'b0;
      debug_on <= 1'b0;
      pair_sel <= `DBG_PAIR_PRIMARY;
      hold_count <= 25'h0;
      powerup_timer_done_o <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        cfg_word[i] <= `CFG_WORD_RESET;
      end
    end else if (ce_i) begin
      case (state)
        ST_LOAD: begin
          if (!issued) begin
            nvm_rd_o <= 1'b1;
            nvm_addr_o <= slot_addr(word_idx);
            issued <= 1'b1;
          end else begin
            nvm_rd_o <= 1'b0;
            cfg_word[word_idx] <= nvm_data_i[`CFG_WORD_BITS-1:0];
            issued <= 1'b0;
            word_idx <= word_idx + 2'h1;
            if (word_idx == 2'h3) begin
              // straps are caught here, after release, not under reset
              debug_on <= dbg_en_sync;
              pair_sel <= strap_sync;
              config_valid_o <= 1'b1;
              hold_count <= 25'h0;
              state <= ST_TIMER;
            end
          end
        end
        ST_TIMER: begin
          // hold-off runs from the captured code, never a live word
          if (hold_code == `HOLD_OFF ||
              hold_count >= powerup_delay_cycles_o - 25'h1) begin
            powerup_timer_done_o <= 1'b1;
            state <= ST_RUN;
          end else begin
            hold_count <= hold_count + 25'h1;
          end
        end
        ST_RUN: begin
          // words stay frozen until the next reset
          state <= ST_RUN;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table reads: 24-bit answer, upper byte zero

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tbl_data_o <= 24'h000000;
      tbl_valid_o <= 1'b0;
    end else if (ce_i) begin
      tbl_valid_o <= tbl_rd_i;
      if (tbl_rd_i) begin
        if (tbl_slot[2]) begin
          tbl_data_o <= 24'h000000;
        end else begin
          tbl_data_o <= {`CFG_PAD_ZERO, cfg_word[tbl_slot[1:0]]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded fields, registered so the core sees clean levels

  // power-up delay doubles per code step from the base
  always @* begin
    if (hold_code == `HOLD_OFF) begin
      next_delay = 25'h0;
    end else begin
      next_delay = HOLD_BASE_CYCLES[24:0] << (hold_code - 3'h1);
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_segment_present_o <= 1'b0;
      boot_high_security_o <= 1'b0;
      boot_segment_end_o <= 24'h000000;
      general_code_protect_o <= 1'b0;
      general_security_reserved_o <= 1'b0;
      watchdog_window_mode_o <= 1'b0;
      watchdog_prescale_o <= `WDT_PRE_LONG;
      watchdog_postscale_o <= `WDT_POST_ONE;
      powerup_delay_cycles_o <= 25'h0;
    end else if (ce_i) begin
      boot_segment_end_o <= boot_end(boot_size);
      boot_segment_present_o <= (boot_end(boot_size) != 24'h0);
      // high security has the top size bit clear
      boot_high_security_o <= (boot_end(boot_size) != 24'h0) &&
                              !boot_size[2];
      general_code_protect_o <= (gen_sec == `GEN_SEC_STD);
      general_security_reserved_o <= !gen_sec[1];
      watchdog_window_mode_o <= !wdt_word[`WDT_WIN_BIT];
      watchdog_prescale_o <= wdt_word[`WDT_PRE_BIT] ?
                             `WDT_PRE_LONG : `WDT_PRE_SHORT;
      // 1111 gives 32768, 1110 gives 16384, down to one for 0000
      watchdog_postscale_o <= `WDT_POST_ONE << post_code;
      powerup_delay_cycles_o <= next_delay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog enable: the fuse overrides the software bit

  assign watchdog_enable_o = config_valid_o &&
                             (wdt_word[`WDT_FUSE_EN_BIT] ||
                              software_watchdog_enable_i);
  // the rc oscillator may only stop when both enables are low
  assign low_power_rc_oscillator_en_o = watchdog_enable_o;

  ////////////////////////////////////////////////////////////////////////////
  // flash write gating, a combinational handshake

  wire in_boot = boot_segment_present_o &&
                 (flash_wr_addr_i > VECTOR_END) &&
                 (flash_wr_addr_i <= boot_segment_end_o);
  // general segment starts after boot, or after vectors when no boot
  wire [23:0] gen_start = boot_segment_present_o ?
                          boot_segment_end_o : VECTOR_END;
  wire in_general = (flash_wr_addr_i > gen_start) &&
                    (flash_wr_addr_i <= FLASH_END);

  assign flash_wr_allow_o = flash_wr_req_i && config_valid_o &&
    !(in_boot && !boot_word[`BOOT_WP_BIT]) &&
    !(in_general && !gen_word[`GEN_WP_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // debugger resources

  // low data RAM is held back from user code while debugging
  assign ram_user_blocked_o = debug_on &&
                              (ram_addr_i < `DBG_RAM_BYTES);
  // the primary pair rides on the programming pins
  assign program_pins_shared_o = debug_on &&
                                 (pair_sel == `DBG_PAIR_PRIMARY);

  // route the debug data line to the selected pair only
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pair
      wire picked = debug_on && (pair_sel == p);
      assign debug_data_pin_o[p] = picked & dbg_data_out_i;
      assign debug_data_pin_oe_o[p] = picked & dbg_data_oe_i;
    end
  endgenerate

  // pair 3 is unused; it reserves nothing and routes nothing
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pair_reserved_o <= 3'h0;
      dbg_data_in_o <= 1'b0;
      dbg_clock_o <= 1'b0;
    end else if (ce_i) begin
      pair_reserved_o <= 3'h0;
      dbg_data_in_o <= 1'b0;
      dbg_clock_o <= 1'b0;
      if (debug_on && pair_sel != 2'b11) begin
        pair_reserved_o[pair_sel] <= 1'b1;
        dbg_data_in_o <= data_sync[pair_sel];
        dbg_clock_o <= clock_sync[pair_sel];
      end
    end
  end

endmodule // config_fuse_decoder

/* File: rtl/config_fuse_decoder_map.vh */
`ifndef CONFIG_FUSE_DECODER_MAP_VH
`define CONFIG_FUSE_DECODER_MAP_VH

// configuration word addresses in table-read space
`define CFG_ADDR_BOOT 24'hf80000
`define CFG_ADDR_GENERAL 24'hf80004
`define CFG_ADDR_WATCHDOG 24'hf8000a
`define CFG_ADDR_POWER_ON 24'hf8000c

// word geometry and erased-cell reset value
`define CFG_WORD_BITS 16
`define CFG_WORD_RESET 16'hffff
`define CFG_PAD_ZERO 8'h00

// boot_segment_config fields
`define BOOT_WP_BIT 0
`define BOOT_SIZE_MSB 3
`define BOOT_SIZE_LSB 1
`define BOOT_SMALL_STD 3'b110
`define BOOT_SMALL_HIGH 3'b010
`define BOOT_MEDIUM_STD 3'b101
`define BOOT_MEDIUM_HIGH 3'b001
`define BOOT_SMALL_END 24'h0003ff
`define BOOT_MEDIUM_END 24'h000fff

// general_segment_config fields
`define GEN_WP_BIT 0
`define GEN_SEC_MSB 2
`define GEN_SEC_LSB 1
`define GEN_SEC_NONE 2'b11
`define GEN_SEC_STD 2'b10

// watchdog_config fields
`define WDT_POST_MSB 3
`define WDT_POST_LSB 0
`define WDT_PRE_BIT 4
`define WDT_WIN_BIT 6
`define WDT_FUSE_EN_BIT 7
`define WDT_PRE_LONG 8'h80
`define WDT_PRE_SHORT 8'h20
`define WDT_POST_ONE 16'h0001

// power_on_config fields
`define HOLD_MSB 2
`define HOLD_LSB 0
`define HOLD_OFF 3'b000
`define HOLD_BASE_MS 2
`define CLK_KHZ 125000

// in-circuit debug resources
`define DBG_RAM_BYTES 16'h0050
`define DBG_PAIR_PRIMARY 2'b00
`define DBG_PAIR_ALT1 2'b01
`define DBG_PAIR_ALT2 2'b10

`endif

/* File: verif/cfg_store_model.sv */
`timescale 1ns/10ps
module cfg_store_model (
  input wire clk_i,
  input wire rd_i,
  input wire [23:0] addr_i,
  input wire [63:0] words_i,
  output wire [23:0] data_o
);
  reg [23:0] junk = 24'h5a5a5a;
  reg [23:0] word;
  // the word stands while the strobe is high, since the device takes it
  // at the edge that ends the strobe; upper byte is junk to be dropped
  always @* begin
    case (addr_i)
      24'hf80000: word = {8'hc3, words_i[15:0]};
      24'hf80004: word = {8'hc3, words_i[31:16]};
      24'hf8000a: word = {8'hc3, words_i[47:32]};
      24'hf8000c: word = {8'hc3, words_i[63:48]};
      default: word = 24'h000000;
    endcase
  end
  // between strobes the bus toggles, so a late capture is caught
  always @(posedge clk_i) begin
    junk <= ~junk;
  end
  assign data_o = rd_i ? word : junk;
endmodule // cfg_store_model

/* File: verif/config_fuse_decoder_chk.sv */
`timescale 1ns/10ps
module config_fuse_decoder_chk (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire nvm_rd_o,
  input wire tbl_rd_i,
  input wire tbl_valid_o,
  input wire flash_wr_req_i,
  input wire flash_wr_allow_o,
  input wire config_valid_o,
  input wire watchdog_enable_o,
  input wire low_power_rc_oscillator_en_o,
  input wire [15:0] watchdog_postscale_o,
  input wire [15:0] ram_addr_i,
  input wire ram_user_blocked_o,
  input wire [2:0] pair_reserved_o,
  input wire program_pins_shared_o,
  input wire powerup_timer_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // a live strobe or table request, frozen flops excluded
  sequence s_strobe;
    nvm_rd_o && ce_i;
  endsequence
  sequence s_table_req;
    tbl_rd_i && ce_i;
  endsequence
  a_strobe_gap: assert property (s_strobe |=> !nvm_rd_o)
    else $error("word strobe too long");
  a_table_answer: assert property (s_table_req |=> tbl_valid_o)
    else $error("table read not answered");
  a_gate_needs_valid: assert property (
    flash_wr_allow_o |-> flash_wr_req_i && config_valid_o)
    else $error("write allowed without request or config");
  a_rc_follows_wdt: assert property (
    low_power_rc_oscillator_en_o == watchdog_enable_o)
    else $error("oscillator enable differs from watchdog");
  a_ram_low_only: assert property (
    ram_user_blocked_o |-> ram_addr_i < 16'h0050)
    else $error("ram blocked above debug area");
  a_post_onehot: assert property (
    config_valid_o |-> $onehot(watchdog_postscale_o))
    else $error("postscale not a power of two");
  a_shared_primary: assert property (
    program_pins_shared_o [*2] |-> pair_reserved_o == 3'h1)
    else $error("shared pins without primary pair");
  a_valid_holds: assert property (config_valid_o |=> config_valid_o)
    else $error("config valid dropped");
  a_done_after_load: assert property (
    powerup_timer_done_o |-> config_valid_o)
    else $error("timer done before load");
endmodule // config_fuse_decoder_chk

bind config_fuse_decoder config_fuse_decoder_chk chk_i (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .ce_i(ce_i),
  .nvm_rd_o(nvm_rd_o),
  .tbl_rd_i(tbl_rd_i),
  .tbl_valid_o(tbl_valid_o),
  .flash_wr_req_i(flash_wr_req_i),
  .flash_wr_allow_o(flash_wr_allow_o),
  .config_valid_o(config_valid_o),
  .watchdog_enable_o(watchdog_enable_o),
  .low_power_rc_oscillator_en_o(low_power_rc_oscillator_en_o),
  .watchdog_postscale_o(watchdog_postscale_o),
  .ram_addr_i(ram_addr_i),
  .ram_user_blocked_o(ram_user_blocked_o),
  .pair_reserved_o(pair_reserved_o),
  .program_pins_shared_o(program_pins_shared_o),
  .powerup_timer_done_o(powerup_timer_done_o)
);

/* File: verif/config_fuse_decoder_tb_top.sv */
`timescale 1ns/10ps
module config_fuse_decoder_tb_top;
  localparam [24:0] BASE = 25'h0000004;
  reg clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg ce_i = 1'b1;
  reg tbl_rd_i = 1'b0;
  reg [23:0] tbl_addr_i = 24'h000000;
  reg flash_wr_req_i = 1'b0;
  reg [23:0] flash_wr_addr_i = 24'h000000;
  reg software_watchdog_enable_i = 1'b0;
  reg debug_enable_i = 1'b0;
  reg [1:0] debug_pair_i = 2'h0;
  reg [15:0] ram_addr_i = 16'h0000;
  reg dbg_data_out_i = 1'b0;
  reg dbg_data_oe_i = 1'b0;
  reg [2:0] debug_data_pin_i = 3'h0;
  reg [2:0] debug_clock_pin_i = 3'h0;
  reg [63:0] words = 64'hffffffffffffffff;
  wire nvm_rd_o, tbl_valid_o, flash_wr_allow_o, config_valid_o;
  wire boot_segment_present_o, boot_high_security_o;
  wire general_code_protect_o, general_security_reserved_o;
  wire watchdog_enable_o, low_power_rc_oscillator_en_o;
  wire watchdog_window_mode_o, powerup_timer_done_o, ram_user_blocked_o;
  wire dbg_data_in_o, dbg_clock_o, program_pins_shared_o;
  wire [23:0] nvm_addr_o, nvm_data_i, tbl_data_o, boot_segment_end_o;
  wire [7:0] watchdog_prescale_o;
  wire [15:0] watchdog_postscale_o;
  wire [24:0] powerup_delay_cycles_o;
  wire [2:0] pair_reserved_o, debug_data_pin_o, debug_data_pin_oe_o;
  integer n_mismatch = 0;
  integer checks = 0;

  // short timer base keeps the longest hold-off at a few hundred cycles
  config_fuse_decoder #(.HOLD_BASE_CYCLES(BASE)) config_fuse_decoder_i (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .nvm_rd_o(nvm_rd_o),
    .nvm_addr_o(nvm_addr_o),
    .nvm_data_i(nvm_data_i),
    .tbl_rd_i(tbl_rd_i),
    .tbl_addr_i(tbl_addr_i),
    .tbl_data_o(tbl_data_o),
    .tbl_valid_o(tbl_valid_o),
    .flash_wr_req_i(flash_wr_req_i),
    .flash_wr_addr_i(flash_wr_addr_i),
    .flash_wr_allow_o(flash_wr_allow_o),
    .config_valid_o(config_valid_o),
    .boot_segment_present_o(boot_segment_present_o),
    .boot_high_security_o(boot_high_security_o),
    .boot_segment_end_o(boot_segment_end_o),
    .general_code_protect_o(general_code_protect_o),
    .general_security_reserved_o(general_security_reserved_o),
    .software_watchdog_enable_i(software_watchdog_enable_i),
    .watchdog_enable_o(watchdog_enable_o),
    .low_power_rc_oscillator_en_o(low_power_rc_oscillator_en_o),
    .watchdog_window_mode_o(watchdog_window_mode_o),
    .watchdog_prescale_o(watchdog_prescale_o),
    .watchdog_postscale_o(watchdog_postscale_o),
    .powerup_timer_done_o(powerup_timer_done_o),
    .powerup_delay_cycles_o(powerup_delay_cycles_o),
    .debug_enable_i(debug_enable_i),
    .debug_pair_i(debug_pair_i),
    .ram_addr_i(ram_addr_i),
    .ram_user_blocked_o(ram_user_blocked_o),
    .pair_reserved_o(pair_reserved_o),
    .dbg_data_out_i(dbg_data_out_i),
    .dbg_data_oe_i(dbg_data_oe_i),
    .dbg_data_in_o(dbg_data_in_o),
    .dbg_clock_o(dbg_clock_o),
    .debug_data_pin_i(debug_data_pin_i),
    .debug_data_pin_o(debug_data_pin_o),
    .debug_data_pin_oe_o(debug_data_pin_oe_o),
    .debug_clock_pin_i(debug_clock_pin_i),
    .program_pins_shared_o(program_pins_shared_o)
  );
  cfg_store_model cfg_store_model_i (.clk_i(clk_i), .rd_i(nvm_rd_o),
    .addr_i(nvm_addr_o), .words_i(words), .data_o(nvm_data_i));

  always #4 clk_i = ~clk_i;

  //////////////////////////////////////////////////////////////////////////
  task chk(input [24:0] seen, input [24:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  // reset with new stored words, wait for the load to finish
  task load(input [63:0] w);
    integer i;
    begin
      @(posedge clk_i);
      words <= w;
      rst_b_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      i = 0;
      while (config_valid_o !== 1'b1 && i < 40) begin
        @(posedge clk_i) #1 i = i + 1;
      end
      chk(i, 8);
      repeat (2) @(posedge clk_i);
      #1;
    end
  endtask

  task rd(input [23:0] a, input [23:0] e);
    begin
      @(posedge clk_i);
      tbl_rd_i <= 1'b1;
      tbl_addr_i <= a;
      @(posedge clk_i);
      tbl_rd_i <= 1'b0;
      #1 chk(tbl_valid_o, 1'b1);
      chk(tbl_data_o, e);
    end
  endtask

  task gate(input [23:0] a, input e);
    begin
      @(posedge clk_i);
      flash_wr_req_i <= 1'b1;
      flash_wr_addr_i <= a;
      #1 chk(flash_wr_allow_o, e);
      @(posedge clk_i);
      flash_wr_req_i <= 1'b0;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  task t_table;
    begin
      load(64'h1e0771c4a5f33c9e);
      rd(24'hf80000, 24'h003c9e);
      rd(24'hf80004, 24'h00a5f3);
      rd(24'hf8000a, 24'h0071c4);
      rd(24'hf8000c, 24'h001e07);
      rd(24'hf80006, 24'h000000);
      @(posedge clk_i);
      words <= 64'h0000000000000000;
      rd(24'hf80000, 24'h003c9e);
      $display("table test done");
    end
  endtask

  // enable low: a pending table read is neither answered nor latched
  task t_freeze;
    begin
      @(posedge clk_i);
      ce_i <= 1'b0;
      tbl_rd_i <= 1'b1;
      tbl_addr_i <= 24'hf8000c;
      repeat (2) @(posedge clk_i);
      #1 chk(tbl_valid_o, 1'b0);
      chk(tbl_data_o, 24'h003c9e);
      @(posedge clk_i);
      ce_i <= 1'b1;
      @(posedge clk_i);
      tbl_rd_i <= 1'b0;
      #1 chk(tbl_valid_o, 1'b1);
      chk(tbl_data_o, 24'h001e07);
      $display("freeze test done");
    end
  endtask

  task t_boot;
    integer c;
    reg [23:0] e;
    begin
      for (c = 0; c < 16; c = c + 1) begin
        load({48'hffffffffffff, 12'hfff, c[3:0]});
        e = c[2:1] == 2'h2 ? 24'h0003ff : c[2:1] == 2'h1 ? 24'h000fff : 0;
        chk(boot_segment_end_o, e);
        chk(boot_segment_present_o, e != 0);
        chk(boot_high_security_o, e != 0 && !c[3]);
        gate(24'h000200, !(e != 0 && !c[0]));
      end
      $display("boot test done");
    end
  endtask

  task t_gen;
    integer c;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        load({32'hffffffff, 13'h1fff, c[2:0], 16'hffff});
        chk(general_code_protect_o, c[2:1] == 2'h2);
        chk(general_security_reserved_o, !c[2]);
        gate(24'h001800, c[0]);
      end
      $display("general test done");
    end
  endtask

  task t_wdt;
    integer c, s;
    begin
      for (c = 0; c < 16; c = c + 1) begin
        load({16'hffff, 8'hff, c[0], c[1], 1'b1, c[2], c[3:0], 32'hffffffff});
        chk(watchdog_postscale_o, 16'h0001 << c);
        chk(watchdog_prescale_o, c[2] ? 8'h80 : 8'h20);
        chk(watchdog_window_mode_o, !c[1]);
        for (s = 0; s < 2; s = s + 1) begin
          @(posedge clk_i);
          software_watchdog_enable_i <= s[0];
          #1 chk(watchdog_enable_o, c[0] | s[0]);
          chk(low_power_rc_oscillator_en_o, c[0] | s[0]);
        end
      end
      $display("watchdog test done");
    end
  endtask

  task t_powerup_timer;
    integer c, n;
    reg [24:0] d;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        load({13'h1fff, c[2:0], 48'hffffffffffff});
        d = c ? BASE << (c - 1) : 0;
        chk(powerup_delay_cycles_o, d);
        n = 0;
        while (powerup_timer_done_o !== 1'b1 && n < 600) begin
          @(posedge clk_i) #1 n = n + 1;
        end
        chk(n + 6 >= d && n <= d + 6, 1'b1);
      end
      $display("timer test done");
    end
  endtask

  task t_dbg;
    integer k;
    reg [2:0] m;
    begin
      for (k = 0; k < 5; k = k + 1) begin
        m = k < 3 ? 3'h1 << k : 3'h0;
        @(posedge clk_i);
        debug_enable_i <= k < 4;
        debug_pair_i <= k[1:0];
        debug_data_pin_i <= 3'h0;
        debug_clock_pin_i <= 3'h0;
        load(64'hffffffffffffffff);
        chk(pair_reserved_o, m);
        chk(program_pins_shared_o, k == 0);
        @(posedge clk_i);
        ram_addr_i <= 16'h004f;
        dbg_data_oe_i <= 1'b1;
        dbg_data_out_i <= 1'b1;
        debug_data_pin_i <= m;
        debug_clock_pin_i <= m;
        #1 chk(ram_user_blocked_o, k < 4);
        chk(debug_data_pin_oe_o, m);
        chk(debug_data_pin_o, m);
        @(posedge clk_i);
        ram_addr_i <= 16'h0050;
        #1 chk(ram_user_blocked_o, 1'b0);
        repeat (3) @(posedge clk_i);
        #1 chk(dbg_data_in_o, m != 0);
        chk(dbg_clock_o, m != 0);
      end
      $display("debug test done");
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // whole run is under two thousand cycles; the limit leaves ample margin
  initial begin
    #150000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end

  initial begin
    t_table;
    t_freeze;
    t_boot;
    t_gen;
    t_wdt;
    t_powerup_timer;
    t_dbg;
    wrap_up;
  end
endmodule // config_fuse_decoder_tb_top
